/* src/onoff_pkg.sv */
// Package: register layout, reset values and decode codes for on/off control
package onoff_pkg;

  // ----------------------------------------------------------------------
  // Register selection and paging
  // ----------------------------------------------------------------------
  localparam logic [7:0] RUN_REG_SEL    = 8'h01;
  localparam logic [7:0] SWITCH_REG_SEL = 8'h02;
  localparam logic [7:0] GLOBAL_PAGE    = 8'hFF;
  localparam int         NUM_CHAN       = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RUN_RESET      = 8'h00;
  localparam logic [7:0] SWITCH_RESET   = 8'h12;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RUN_CTRL_HI   = 7;
  localparam int RUN_CTRL_LO   = 6;
  localparam int MARGIN_HI     = 5;
  localparam int MARGIN_LO     = 4;
  localparam int FAULT_HI      = 3;
  localparam int FAULT_LO      = 2;
  localparam int SW_GATED_BIT  = 4;
  localparam int SW_USE_BUS    = 3;
  localparam int SW_USE_PIN    = 2;
  localparam int SW_ONE_BIT    = 1;
  localparam int SW_FAST_OFF   = 0;
  localparam logic [7:0] SW_WRITE_MASK = 8'h1D;
  localparam logic [7:0] SW_READ_ONES  = 8'h02;
  localparam logic [7:0] RUN_WRITE_MASK = 8'hFC;

  // ----------------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] CTRL_OFF_NOW  = 2'h0;
  localparam logic [1:0] CTRL_SEQ_OFF  = 2'h1;
  localparam logic [1:0] CTRL_SEQ_ON   = 2'h2;
  localparam logic [1:0] MARG_NOMINAL  = 2'h0;
  localparam logic [1:0] MARG_LOW      = 2'h1;
  localparam logic [1:0] MARG_HIGH     = 2'h2;
  localparam logic [1:0] FLT_IGNORE    = 2'h1;
  localparam logic [1:0] FLT_ACT       = 2'h2;

  typedef enum logic [1:0] {
    LEVEL_NOMINAL,
    LEVEL_LOW,
    LEVEL_HIGH
  } level_t;

  typedef enum logic [2:0] {
    CH_WAIT_INIT,
    CH_WAIT_INPUT,
    CH_OFF,
    CH_SEQ_ON,
    CH_ON,
    CH_SEQ_OFF
  } chan_state_t;

endpackage

/* src/run_decode.sv */
// Run register legality check and level/fault decode for one channel
`timescale 1ns/100ps
module run_decode
  import onoff_pkg::*;
(
  input  wire logic [7:0] run_byte_i,
  input  wire logic       use_bus_i,
  output logic            legal_o,
  output level_t          level_o,
  output logic            ignore_faults_o
);

  logic [1:0] ctrl;
  logic [1:0] marg;
  logic [1:0] flt;

  // --------------------------------------------------------------------
  // Field split and decode
  // --------------------------------------------------------------------
  always_comb begin
    ctrl = run_byte_i[RUN_CTRL_HI:RUN_CTRL_LO];
    marg = run_byte_i[MARGIN_HI:MARGIN_LO];
    flt  = run_byte_i[FAULT_HI:FAULT_LO];
    legal_o = 1'b1;
    // Off-now with the bus bit set is legal whatever the margin and fault fields
    if (use_bus_i && ctrl == CTRL_OFF_NOW) begin
      legal_o = 1'b1;
    end else if (ctrl == 2'h3) begin
      legal_o = 1'b0;
    end else if (marg == 2'h3) begin
      legal_o = 1'b0;
    end else if (marg != MARG_NOMINAL &&
                 flt != FLT_IGNORE && flt != FLT_ACT) begin
      legal_o = 1'b0; // Reserved combination
    end
    // Margin select decodes alike whatever the run field
    unique case (marg)
      MARG_LOW:  level_o = LEVEL_LOW;
      MARG_HIGH: level_o = LEVEL_HIGH;
      default:   level_o = LEVEL_NOMINAL;
    endcase
    // Fault policy only counts while margining
    ignore_faults_o = (marg != MARG_NOMINAL) && (flt == FLT_IGNORE);
  end

endmodule

/* src/channel_on_off_control.sv */
// Per-channel on/off, margin and fault-policy decision logic
`timescale 1ns/100ps
module channel_on_off_control
  import onoff_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  input  wire logic                wr_en_i,
  input  wire logic [7:0]          wr_sel_i,
  input  wire logic [7:0]          wr_page_i,
  input  wire logic [7:0]          wr_data_i,
  input  wire logic [7:0]          rd_sel_i,
  input  wire logic [7:0]          rd_page_i,
  input  wire logic                init_done_i,
  input  wire logic                input_on_threshold_i,
  input  wire logic [NUM_CHAN-1:0] control_pin_i,
  input  wire logic [NUM_CHAN-1:0] turn_on_delay_done_i,
  input  wire logic [NUM_CHAN-1:0] turn_off_delay_done_i,
  output logic [7:0]               rd_data_o,
  output logic [NUM_CHAN-1:0]      turn_on_delay_start_o,
  output logic [NUM_CHAN-1:0]      turn_off_delay_start_o,
  output logic [NUM_CHAN-1:0]      output_enable_o,
  output logic [NUM_CHAN-1:0]      fast_off_o,
  output logic [2*NUM_CHAN-1:0]    level_o,
  output logic [NUM_CHAN-1:0]      ignore_faults_o
);

  logic [7:0]            run_reg     [NUM_CHAN];
  logic [7:0]            run_next    [NUM_CHAN];
  logic [7:0]            sw_reg      [NUM_CHAN];
  logic [7:0]            sw_next     [NUM_CHAN];
  chan_state_t           st_reg      [NUM_CHAN];
  chan_state_t           st_next     [NUM_CHAN];
  logic [7:0]            rd_data_next;
  logic [NUM_CHAN-1:0]   on_start_next;
  logic [NUM_CHAN-1:0]   off_start_next;
  logic [NUM_CHAN-1:0]   oe_next;
  logic [NUM_CHAN-1:0]   fast_next;
  logic [2*NUM_CHAN-1:0] level_next;
  logic [NUM_CHAN-1:0]   ign_next;
  logic [NUM_CHAN-1:0]   legal_w;
  logic [NUM_CHAN-1:0]   ign_w;
  level_t                lvl_w       [NUM_CHAN];
  logic [NUM_CHAN-1:0]   want_on;
  logic [NUM_CHAN-1:0]   bus_off_now;
  logic [NUM_CHAN-1:0]   pin_off;

  // True when a page targets this channel, directly or globally
  function automatic logic page_hit(input logic [7:0] page, input int ch);
    page_hit = (page == GLOBAL_PAGE) || (page == 8'(ch));
  endfunction

  // --------------------------------------------------------------------
  // Run field decode per channel
  // --------------------------------------------------------------------
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_dec
    run_decode u_dec (
      .run_byte_i      (run_reg[g]),
      .use_bus_i       (sw_reg[g][SW_USE_BUS]),
      .legal_o         (legal_w[g]),
      .level_o         (lvl_w[g]),
      .ignore_faults_o (ign_w[g])
    );
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      run_next[c] = run_reg[c];
      sw_next[c]  = sw_reg[c];
      if (wr_en_i && page_hit(wr_page_i, c)) begin
        if (wr_sel_i == RUN_REG_SEL) begin
          run_next[c] = wr_data_i & RUN_WRITE_MASK;
        end
        if (wr_sel_i == SWITCH_REG_SEL) begin
          // Upper bits dropped, bit 1 forced high
          sw_next[c] = (wr_data_i & SW_WRITE_MASK) | SW_READ_ONES;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // On/off request decode
  // --------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      logic bus_on;
      logic bus_ok;
      logic pin_ok;
      bus_on = run_reg[c][RUN_CTRL_HI:RUN_CTRL_LO] == CTRL_SEQ_ON;
      bus_off_now[c] = 1'b0;
      // Run field only counts with the bus bit
      bus_ok = !sw_reg[c][SW_USE_BUS] || bus_on;
      pin_ok = !sw_reg[c][SW_USE_PIN] || control_pin_i[c];
      pin_off[c] = sw_reg[c][SW_USE_PIN] && !control_pin_i[c];
      if (!sw_reg[c][SW_GATED_BIT]) begin
        want_on[c] = 1'b1;
      end else if (!sw_reg[c][SW_USE_BUS] && !sw_reg[c][SW_USE_PIN]) begin
        want_on[c] = 1'b0;
      end else begin
        want_on[c] = bus_ok && pin_ok;
      end
      if (sw_reg[c][SW_GATED_BIT] && sw_reg[c][SW_USE_BUS] &&
          run_reg[c][RUN_CTRL_HI:RUN_CTRL_LO] == CTRL_OFF_NOW) begin
        bus_off_now[c] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Channel sequencing state
  // --------------------------------------------------------------------
  always_comb begin
    on_start_next  = '0;
    off_start_next = '0;
    oe_next        = '0;
    fast_next      = '0;
    level_next     = level_o;
    ign_next       = ignore_faults_o;
    for (int c = 0; c < NUM_CHAN; c++) begin
      st_next[c] = st_reg[c];
      // Reserved run bytes leave level and policy untouched
      if (legal_w[c]) begin
        level_next[2*c +: 2] = lvl_w[c];
        ign_next[c]          = ign_w[c];
      end
      unique case (st_reg[c])
        CH_WAIT_INIT:
          if (init_done_i) st_next[c] = CH_WAIT_INPUT;
        CH_WAIT_INPUT:
          if (input_on_threshold_i) st_next[c] = CH_OFF;
        CH_OFF:
          if (want_on[c] && legal_w[c]) begin
            st_next[c]       = CH_SEQ_ON;
            on_start_next[c] = 1'b1;
          end
        CH_SEQ_ON: begin
          if (!want_on[c]) begin
            st_next[c] = CH_OFF;
          end else if (turn_on_delay_done_i[c]) begin
            st_next[c] = CH_ON;
            oe_next[c] = 1'b1;
          end
        end
        CH_ON: begin
          oe_next[c] = 1'b1;
          if (bus_off_now[c] || (pin_off[c] &&
              sw_reg[c][SW_FAST_OFF])) begin
            // Drop at once, no active discharge
            st_next[c]   = CH_OFF;
            oe_next[c]   = 1'b0;
            fast_next[c] = 1'b1;
          end else if (pin_off[c] || (!want_on[c] && legal_w[c])) begin
            // Pin off still acts while a reserved run byte is held
            st_next[c]        = CH_SEQ_OFF;
            off_start_next[c] = 1'b1;
          end
        end
        CH_SEQ_OFF: begin
          oe_next[c] = 1'b1;
          if (turn_off_delay_done_i[c]) begin
            st_next[c] = CH_OFF;
            oe_next[c] = 1'b0;
          end
        end
        default: st_next[c] = CH_WAIT_INIT;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Read mux, registered to keep outputs glitch free
  // --------------------------------------------------------------------
  always_comb begin
    rd_data_next = 8'h00;
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (rd_page_i == 8'(c)) begin
        if (rd_sel_i == RUN_REG_SEL) rd_data_next = run_reg[c];
        if (rd_sel_i == SWITCH_REG_SEL) rd_data_next = sw_reg[c];
      end
    end
  end

  // --------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        run_reg[c] <= RUN_RESET;
        sw_reg[c]  <= SWITCH_RESET;
        st_reg[c]  <= CH_WAIT_INIT;
      end
      rd_data_o              <= 8'h00;
      turn_on_delay_start_o  <= '0;
      turn_off_delay_start_o <= '0;
      output_enable_o        <= '0;
      fast_off_o             <= '0;
      level_o                <= '0;
      ignore_faults_o        <= '0;
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        run_reg[c] <= run_next[c];
        sw_reg[c]  <= sw_next[c];
        st_reg[c]  <= st_next[c];
      end
      rd_data_o              <= rd_data_next;
      turn_on_delay_start_o  <= on_start_next;
      turn_off_delay_start_o <= off_start_next;
      output_enable_o        <= oe_next;
      fast_off_o             <= fast_next;
      level_o                <= level_next;
      ignore_faults_o        <= ign_next;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sw_upper_zero_a: assert property (
    sw_reg[0][7:5] == 3'h0 && sw_reg[1][7:5] == 3'h0)
    else $error("switch config upper bits not zero");
  sw_bit_one_a: assert property (
    sw_reg[0][SW_ONE_BIT] && sw_reg[1][SW_ONE_BIT])
    else $error("switch config bit 1 not one");
  run_low_zero_a: assert property (
    run_reg[0][1:0] == 2'h0 && run_reg[1][1:0] == 2'h0)
    else $error("run register low bits not zero");
  global_write_a: assert property (
    wr_en_i && wr_page_i == GLOBAL_PAGE && wr_sel_i == RUN_REG_SEL
    |=> run_reg[0] == run_reg[1])
    else $error("global page write missed a channel");
  init_hold_a: assert property (
    st_reg[0] == CH_WAIT_INIT && !init_done_i |=> !turn_on_delay_start_o[0])
    else $error("turn-on delay started before init");
  input_hold_a: assert property (
    st_reg[0] == CH_WAIT_INPUT && !input_on_threshold_i
    |=> !turn_on_delay_start_o[0] [*2])
    else $error("sequencing before input threshold");
  never_on_a: assert property (
    st_reg[0] == CH_OFF && sw_reg[0][4:2] == 3'b100
    |=> !turn_on_delay_start_o[0])
    else $error("gated channel with no source powered up");
  ungated_on_a: assert property (
    st_reg[0] == CH_OFF && !sw_reg[0][SW_GATED_BIT] && legal_w[0]
    |=> turn_on_delay_start_o[0])
    else $error("ungated channel failed to start");
  pin_required_a: assert property (
    st_reg[0] == CH_OFF && sw_reg[0][SW_USE_PIN] && sw_reg[0][SW_GATED_BIT]
    && !control_pin_i[0] |=> !turn_on_delay_start_o[0])
    else $error("started without control pin");
  fast_off_a: assert property (
    st_reg[0] == CH_ON && pin_off[0] && sw_reg[0][SW_FAST_OFF]
    |=> !output_enable_o[0] && fast_off_o[0])
    else $error("fast off not immediate");
  slow_off_a: assert property (
    st_reg[0] == CH_ON && pin_off[0] && !sw_reg[0][SW_FAST_OFF]
    && !bus_off_now[0]
    |=> output_enable_o[0] && turn_off_delay_start_o[0])
    else $error("slow off skipped turn-off delay");

  on_seen_c:   cover property (st_reg[0] == CH_ON);
  seq_off_c:   cover property (st_reg[0] == CH_SEQ_OFF ##1
                               st_reg[0] == CH_OFF);
  margin_c:    cover property (level_o[1:0] == 2'(LEVEL_HIGH));
  fast_c:      cover property (fast_off_o[0]);

endmodule

/* testbench/onoff_partner.sv */
// Delay timer and control pin driver models facing the on/off block
`timescale 1ns/100ps
module onoff_partner
  import onoff_pkg::*;
#(
  parameter int DLY     = 6,
  parameter int OFF_MIN = 8
)(
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  input  wire logic [NUM_CHAN-1:0] pin_req_i,
  input  wire logic [NUM_CHAN-1:0] on_start_i,
  input  wire logic [NUM_CHAN-1:0] off_start_i,
  output logic [NUM_CHAN-1:0]      control_pin_o,
  output logic [NUM_CHAN-1:0]      on_done_o,
  output logic [NUM_CHAN-1:0]      off_done_o
);
  int on_cnt  [NUM_CHAN];
  int off_cnt [NUM_CHAN];
  int low_cnt [NUM_CHAN];

  // Timers pulse done DLY cycles after start; pin keeps its off time
  always @(posedge sys_clk_i) begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (rst_i) begin
        on_cnt[c]        <= 0;
        off_cnt[c]       <= 0;
        low_cnt[c]       <= OFF_MIN;
        on_done_o[c]     <= 1'b0;
        off_done_o[c]    <= 1'b0;
        control_pin_o[c] <= 1'b0;
      end else begin
        on_done_o[c]  <= (on_cnt[c] == 1);
        off_done_o[c] <= (off_cnt[c] == 1);
        on_cnt[c]  <= on_start_i[c] ? DLY
                      : (on_cnt[c] > 0 ? on_cnt[c] - 1 : 0);
        off_cnt[c] <= off_start_i[c] ? DLY
                      : (off_cnt[c] > 0 ? off_cnt[c] - 1 : 0);
        // Early re-assert is held back until the off time has run
        if (control_pin_o[c] && !pin_req_i[c]) begin
          control_pin_o[c] <= 1'b0;
          low_cnt[c]       <= 0;
        end else if (!control_pin_o[c]) begin
          control_pin_o[c] <= pin_req_i[c] && (low_cnt[c] >= OFF_MIN);
          low_cnt[c]       <= (low_cnt[c] < OFF_MIN) ? low_cnt[c] + 1
                              : OFF_MIN;
        end
      end
    end
  end
endmodule

/* testbench/channel_on_off_control_test.sv */
// Self-checking bench for the channel on/off decision block
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module channel_on_off_control_test;
  import onoff_pkg::*;
  localparam int OFF_MIN = 8;
  logic                  sys_clk_i, rst_i, wr_en_i;
  logic [7:0]            wr_sel_i, wr_page_i, wr_data_i, rd_sel_i, rd_page_i;
  logic                  init_done_i, input_on_threshold_i;
  logic [NUM_CHAN-1:0]   pin_req, pin, on_dn, off_dn, on_st, off_st;
  logic [NUM_CHAN-1:0]   en, fast, ign, fast_seen, on_seen, off_seen;
  logic [7:0]            rd_data_o;
  logic [2*NUM_CHAN-1:0] lvl;
  logic [7:0]            set_val [3];
  logic [1:0]            set_lvl [3];
  int                    num_errors, cmp_count;

  channel_on_off_control uut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
    .wr_sel_i(wr_sel_i), .wr_page_i(wr_page_i), .wr_data_i(wr_data_i),
    .rd_sel_i(rd_sel_i), .rd_page_i(rd_page_i), .init_done_i(init_done_i),
    .input_on_threshold_i(input_on_threshold_i), .control_pin_i(pin),
    .turn_on_delay_done_i(on_dn), .turn_off_delay_done_i(off_dn),
    .rd_data_o(rd_data_o), .turn_on_delay_start_o(on_st),
    .turn_off_delay_start_o(off_st), .output_enable_o(en),
    .fast_off_o(fast), .level_o(lvl), .ignore_faults_o(ign));

  onoff_partner #(.DLY(6), .OFF_MIN(OFF_MIN)) far_side (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_req_i(pin_req),
    .on_start_i(on_st), .off_start_i(off_st), .control_pin_o(pin),
    .on_done_o(on_dn), .off_done_o(off_dn));

  // --------------------------------------------------------------------
  // Clock and pulse catchers
  // --------------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // Sticky flags, since start and fast-off pulses last one cycle only
  always @(posedge sys_clk_i) begin
    fast_seen <= rst_i ? '0 : (fast_seen | fast);
    on_seen   <= rst_i ? '0 : (on_seen | on_st);
    off_seen  <= rst_i ? '0 : (off_seen | off_st);
  end

  // --------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------
  task automatic wr(input logic [7:0] sel, input logic [7:0] pg,
                    input logic [7:0] d);
    @(negedge sys_clk_i);
    wr_sel_i  = sel;
    wr_page_i = pg;
    wr_data_i = d;
    wr_en_i   = 1'b1;
    @(negedge sys_clk_i);
    wr_en_i   = 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the select
  task automatic chk_rd(input logic [7:0] sel, input logic [7:0] pg,
                        input logic [7:0] exp);
    @(negedge sys_clk_i);
    rd_sel_i  = sel;
    rd_page_i = pg;
    @(negedge sys_clk_i);
    `CHK(rd_data_o, exp)
  endtask

  task automatic wait_en(input int ch, input logic val);
    int n = 0;
    while (en[ch] !== val && n < 60) begin
      @(negedge sys_clk_i);
      n++;
    end
    cmp_count++;
    if (en[ch] !== val) begin
      num_errors++;
      $display("[FAIL] %0t enable %0d never reached %b", $time, ch, val);
      conclude();
    end
  endtask

  task automatic conclude;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {wr_en_i, wr_sel_i, wr_page_i, wr_data_i, rd_sel_i, rd_page_i} = '0;
    {init_done_i, input_on_threshold_i, pin_req} = '0;
    {num_errors, cmp_count} = '0;
    set_val = '{8'h28, 8'h18, 8'h48};
    set_lvl = '{2'h2, 2'h1, 2'h0};
    rst_i = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    chk_rd(RUN_REG_SEL, 8'h01, 8'h00);
    chk_rd(SWITCH_REG_SEL, 8'h01, 8'h12);
    wr(SWITCH_REG_SEL, 8'h00, 8'hFF);
    chk_rd(SWITCH_REG_SEL, 8'h00, 8'h1F);
    wr(SWITCH_REG_SEL, 8'h00, 8'h00);
    chk_rd(SWITCH_REG_SEL, 8'h00, 8'h02);
    wr(RUN_REG_SEL, 8'h00, 8'hFF);
    chk_rd(RUN_REG_SEL, 8'h00, 8'hFC);
    wr(SWITCH_REG_SEL, GLOBAL_PAGE, 8'h1C);
    chk_rd(SWITCH_REG_SEL, 8'h00, 8'h1E);
    chk_rd(SWITCH_REG_SEL, 8'h01, 8'h1E);
    wr(SWITCH_REG_SEL, 8'h01, 8'h18);
    wr(RUN_REG_SEL, GLOBAL_PAGE, 8'hA8);
    chk_rd(RUN_REG_SEL, 8'h00, 8'hA8);
    wr(RUN_REG_SEL, 8'h00, 8'h94);
    wr(RUN_REG_SEL, 8'h01, 8'hA8);
    // Input good but still initializing: no sequencing may start
    input_on_threshold_i = 1'b1;
    repeat (20) @(negedge sys_clk_i);
    `CHK(on_seen, 2'b00)
    input_on_threshold_i = 1'b0;
    init_done_i = 1'b1;
    // Init done but input below threshold: still no sequencing may start
    repeat (20) @(negedge sys_clk_i);
    `CHK(on_seen, 2'b00)
    input_on_threshold_i = 1'b1;
    wait_en(1, 1'b1);
    `CHK(lvl[3:2], 2'h2)
    `CHK(ign[1], 1'b0)
    `CHK(en[0], 1'b0)
    pin_req[0] = 1'b1;
    wait_en(0, 1'b1);
    `CHK(lvl[1:0], 2'h1)
    `CHK(ign[0], 1'b1)
    wr(RUN_REG_SEL, 8'h00, 8'hD4);
    repeat (4) @(negedge sys_clk_i);
    `CHK({en[0], lvl[1:0], ign[0]}, 4'hB)
    // Slow pin off runs through the turn-off delay
    pin_req[0] = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    `CHK(en[0], 1'b1)
    wait_en(0, 1'b0);
    `CHK(off_seen[0], 1'b1)
    `CHK(fast_seen[0], 1'b0)
    wr(RUN_REG_SEL, 8'h01, 8'h48);
    repeat (3) @(negedge sys_clk_i);
    `CHK(en[1], 1'b1)
    wait_en(1, 1'b0);
    repeat (OFF_MIN) @(negedge sys_clk_i);
    wr(RUN_REG_SEL, 8'h01, 8'hA8);
    wait_en(1, 1'b1);
    wr(RUN_REG_SEL, 8'h01, 8'h08);
    repeat (2) @(negedge sys_clk_i);
    `CHK({en[1], fast_seen[1]}, 2'b01)
    // Fast pin off drops the output within two edges
    wr(SWITCH_REG_SEL, 8'h00, 8'h1D);
    wr(RUN_REG_SEL, 8'h00, 8'h94);
    pin_req[0] = 1'b1;
    wait_en(0, 1'b1);
    pin_req[0] = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    `CHK({en[0], fast_seen[0]}, 2'b01)
    // Bus bit clear: run field ignored, margin field still obeyed
    wr(SWITCH_REG_SEL, 8'h01, 8'h14);
    wr(RUN_REG_SEL, 8'h01, 8'h28);
    pin_req[1] = 1'b1;
    wait_en(1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(RUN_REG_SEL, 8'h01, set_val[i]);
      repeat (4) @(negedge sys_clk_i);
      `CHK({en[1], lvl[3:2]}, {1'b1, set_lvl[i]})
    end
    // Gated with neither source honoured never powers up
    wr(SWITCH_REG_SEL, 8'h00, 8'h10);
    pin_req[0] = 1'b1;
    repeat (30) @(negedge sys_clk_i);
    `CHK(en[0], 1'b0)
    wr(SWITCH_REG_SEL, 8'h00, 8'h02);
    wait_en(0, 1'b1);
    conclude();
  end
endmodule
